// ===== core/brmc_pkg.sv
// Purpose: constants and types for the boot reset mode controller
// Assumes: 125 MHz system clock, all inputs synchronous to it
// Notes: timing figures in their own units, cycle counts derived below
package brmc_pkg;
  localparam int unsigned BRMC_CLK_HZ = 125000000;
  localparam int unsigned BRMC_RESET_MS = 501;
  localparam int unsigned BRMC_RESET_CYCLES = BRMC_RESET_MS * (BRMC_CLK_HZ / 1000);
  localparam int unsigned BRMC_DEBOUNCE_US = 10000;
  localparam int unsigned BRMC_DEBOUNCE_CYCLES = BRMC_DEBOUNCE_US * (BRMC_CLK_HZ / 1000000);
  localparam int unsigned BRMC_TIMER_W = 27;
  localparam int unsigned BRMC_DB_W = 21;
  localparam int unsigned BRMC_MODE_W = 4;
  localparam int unsigned BRMC_NMI_PULSE_CYCLES = 8;
  localparam int unsigned BRMC_NMI_W = 4;
  localparam int unsigned BRMC_PWRUP_W = 4;
  localparam logic [BRMC_MODE_W-1:0] BRMC_BOOT_MODE = 4'h0;
  typedef enum logic [1:0] {
    BRMC_USER_RESET,
    BRMC_USER_RUN,
    BRMC_BOOT_RESET,
    BRMC_BOOT_RUN
  } brmc_state_t;
endpackage

// ===== core/brmc_debounce.sv
// Purpose: synchronise and debounce one active-low button
// Assumes: input raw level, press is low
// Notes: outputs a clean level and a one-cycle press pulse
`timescale 1ns/100ps
module brmc_debounce #(
  parameter int unsigned STABLE_CYCLES = brmc_pkg::BRMC_DEBOUNCE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic button_n_in,
  output logic pressed_out,
  output logic press_pulse_out
);
  import brmc_pkg::*;
  logic sync1_r;
  logic sync2_r;
  logic [BRMC_DB_W-1:0] cnt_r;
  logic stable_r;

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= ~button_n_in;
      sync2_r <= sync1_r;
    end
  end

  // level must hold for the full window before it is believed
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      cnt_r <= '0;
      stable_r <= 1'b0;
      press_pulse_out <= 1'b0;
    end else begin
      press_pulse_out <= 1'b0;
      if (sync2_r == stable_r) begin
        cnt_r <= '0;
      end else if (cnt_r == BRMC_DB_W'(STABLE_CYCLES - 1)) begin
        cnt_r <= '0;
        stable_r <= sync2_r;
        press_pulse_out <= sync2_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign pressed_out = stable_r;
endmodule

// ===== core/brmc_top.sv
// Purpose: boot reset mode controller for a target microcontroller
// Assumes: buttons and cts active low, synchronous inputs
// Notes: reset_in models power-up detection; mode pins are tri-state
`timescale 1ns/100ps
module brmc_top #(
  parameter int unsigned RESET_CYCLES = brmc_pkg::BRMC_RESET_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = brmc_pkg::BRMC_DEBOUNCE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic reset_button_n_in,
  input wire logic boot_button_n_in,
  input wire logic nmi_button_n_in,
  input wire logic host_cts_n_in,
  input wire logic user_program_enable_option_in,
  output logic target_reset_n_out,
  output logic target_nmi_n_out,
  output logic [brmc_pkg::BRMC_MODE_W-1:0] mode_pin_out,
  output logic [brmc_pkg::BRMC_MODE_W-1:0] mode_pin_oe_out,
  output logic flash_write_protect_out,
  output logic host_rts_out,
  output logic boot_led_out
);
  import brmc_pkg::*;

  brmc_state_t state_r;
  brmc_state_t state_nxt;
  logic [BRMC_TIMER_W-1:0] timer_r;
  logic timer_done;
  logic rst_pressed;
  logic rst_pulse;
  logic boot_pressed;
  logic boot_pulse;
  logic cts_pressed;
  logic cts_pulse;
  logic nmi_pulse;
  logic boot_req;
  logic hold_req;
  logic restart;
  logic [BRMC_NMI_W-1:0] nmi_cnt_r;
  logic reset_n_r;
  logic boot_r;
  logic wp_r;

  function automatic logic is_boot(input brmc_state_t s);
    is_boot = (s == BRMC_BOOT_RESET) || (s == BRMC_BOOT_RUN);
  endfunction

  function automatic logic is_reset(input brmc_state_t s);
    is_reset = (s == BRMC_USER_RESET) || (s == BRMC_BOOT_RESET);
  endfunction

  brmc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_rst (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .button_n_in(reset_button_n_in),
    .pressed_out(rst_pressed),
    .press_pulse_out(rst_pulse)
  );

  brmc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_boot (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .button_n_in(boot_button_n_in),
    .pressed_out(boot_pressed),
    .press_pulse_out(boot_pulse)
  );

  brmc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_cts (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .button_n_in(host_cts_n_in),
    .pressed_out(cts_pressed),
    .press_pulse_out(cts_pulse)
  );

  // nmi uses only the edge; hold time beyond the debounce window does not matter
  brmc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_nmi (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .button_n_in(nmi_button_n_in),
    .pressed_out(),
    .press_pulse_out(nmi_pulse)
  );

  assign boot_req = boot_pulse | cts_pulse;
  // held input keeps the timer at zero so release adds a full period
  assign hold_req = rst_pressed | boot_pressed | cts_pressed;
  assign restart = rst_pulse | boot_req;
  assign timer_done = (timer_r == BRMC_TIMER_W'(RESET_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BRMC_USER_RESET: begin
        // boot press here only stretches reset, never switches mode
        if (timer_done && !hold_req) begin
          state_nxt = BRMC_USER_RUN;
        end
      end
      BRMC_USER_RUN: begin
        if (boot_req) begin
          state_nxt = BRMC_BOOT_RESET;
        end else if (rst_pulse) begin
          state_nxt = BRMC_USER_RESET;
        end
      end
      BRMC_BOOT_RESET: begin
        if (timer_done && !hold_req) begin
          state_nxt = BRMC_BOOT_RUN;
        end
      end
      BRMC_BOOT_RUN: begin
        if (boot_req || rst_pulse) begin
          state_nxt = BRMC_USER_RESET;
        end
      end
      default: begin
        state_nxt = BRMC_USER_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_r <= BRMC_USER_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // reset timer on the system clock; restarts on every new reset, boot or cts press
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer_r <= '0;
    end else if (!is_reset(state_r) || restart || hold_req) begin
      timer_r <= '0;
    end else if (!timer_done) begin
      timer_r <= timer_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      reset_n_r <= 1'b0;
      boot_r <= 1'b0;
    end else begin
      reset_n_r <= !is_reset(state_nxt);
      boot_r <= is_boot(state_nxt);
    end
  end

  // fixed-width nmi pulse; only while the target runs user code
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      nmi_cnt_r <= '0;
    end else if (nmi_pulse && state_r == BRMC_USER_RUN && nmi_cnt_r == '0) begin
      nmi_cnt_r <= BRMC_NMI_W'(BRMC_NMI_PULSE_CYCLES);
    end else if (nmi_cnt_r != '0) begin
      nmi_cnt_r <= nmi_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      wp_r <= 1'b1;
    end else begin
      wp_r <= ~user_program_enable_option_in;
    end
  end

  assign target_reset_n_out = reset_n_r;
  assign target_nmi_n_out = (nmi_cnt_r == '0);
  assign mode_pin_out = BRMC_BOOT_MODE;
  // released in user states so board jumpers pick the mode
  assign mode_pin_oe_out = {BRMC_MODE_W{boot_r}};
  assign flash_write_protect_out = wp_r;
  assign host_rts_out = boot_r;
  assign boot_led_out = boot_r;

  AST_PWRUP_RESET: assert property (@(posedge clk_sys_in)
    $fell(reset_in) |-> !target_reset_n_out[*3])
    else $error("reset not held after power-up");
  AST_RESET_MIN: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(target_reset_n_out) |-> $past(timer_done))
    else $error("reset released before timer expiry");
  AST_BOOT_DRIVE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == BRMC_BOOT_RESET) |=> (mode_pin_oe_out == 4'hf) && (mode_pin_out == BRMC_BOOT_MODE))
    else $error("mode pins not forced in boot reset");
  AST_USER_FLOAT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == BRMC_USER_RUN) && $stable(state_r) |-> mode_pin_oe_out == 4'h0)
    else $error("mode pins driven in user mode");
  AST_NO_BOOT_IN_RESET: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == BRMC_USER_RESET) |=> state_r != BRMC_BOOT_RESET)
    else $error("boot entered from user reset");
  AST_RESTART: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    is_reset(state_r) && restart |=> timer_r == '0)
    else $error("timer not restarted");
  AST_TOGGLE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (state_r == BRMC_USER_RUN) && boot_req |=> state_r == BRMC_BOOT_RESET ##1 !target_reset_n_out)
    else $error("boot press did not enter boot reset");
  AST_NMI_WIDTH: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $fell(target_nmi_n_out) |-> !target_nmi_n_out[*8] ##1 target_nmi_n_out)
    else $error("nmi pulse width wrong");
  AST_RTS: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    host_rts_out == boot_led_out && host_rts_out == mode_pin_oe_out[0])
    else $error("rts disagrees with mode");
  AST_WP: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ##1 flash_write_protect_out == !$past(user_program_enable_option_in))
    else $error("write protect not following jumper");
endmodule

// ===== tb/brmc_target_model.sv
// Purpose: behavioural target that watches reset, mode and nmi pins
// Assumes: mode pins already resolved against the jumper pulls
// Notes: counts nmi pulses only while out of reset
`timescale 1ns/100ps
module brmc_target_model
  import brmc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic target_reset_n_in,
  input wire logic target_nmi_n_in,
  input wire logic [brmc_pkg::BRMC_MODE_W-1:0] mode_pin_in,
  output logic [brmc_pkg::BRMC_MODE_W-1:0] latched_mode_out,
  output int nmi_count_out,
  output int nmi_width_out
);
  logic nmi_d_r = 1'b1;
  int width_r = 0;
  initial begin
    latched_mode_out = '0;
    nmi_count_out = 0;
    nmi_width_out = 0;
  end
  always @(posedge clk_sys_in) begin
    if (target_reset_n_in === 1'b0) begin
      latched_mode_out <= mode_pin_in;
    end
    nmi_d_r <= target_nmi_n_in;
    if (target_nmi_n_in === 1'b0) begin
      width_r <= (nmi_d_r === 1'b1) ? 1 : width_r + 1;
    end
    if (target_nmi_n_in === 1'b0 && nmi_d_r === 1'b1 && target_reset_n_in === 1'b1) begin
      nmi_count_out <= nmi_count_out + 1;
    end
    if (target_nmi_n_in === 1'b1 && nmi_d_r === 1'b0) begin
      nmi_width_out <= width_r;
    end
  end
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for the boot reset mode controller
// Assumes: short reset and debounce counts via parameters
// Notes: status vector packs reset, rts, led, mode enables and mode value
`timescale 1ns/100ps
module testbench;
  import brmc_pkg::*;
  localparam int unsigned RST_CYC = 50;
  localparam int unsigned DB_CYC = 4;
  localparam logic [BRMC_MODE_W-1:0] JUMPER_MODE = 4'he;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] btn_n = 4'hf; // 0 reset, 1 boot, 2 nmi, 3 cts
  logic upe = 1'b0;
  logic rst_n, nmi_n, wp, rts, led;
  logic [BRMC_MODE_W-1:0] md_out, md_oe, md_bus, latched;
  logic [10:0] st;
  int nmi_cnt, nmi_w, t;
  int error_cnt = 0;
  int n_checks = 0;
  // undriven mode pins fall back to the jumper pulls
  assign md_bus = (md_oe & md_out) | (~md_oe & JUMPER_MODE);
  assign st = {rst_n, rts, led, md_oe, md_out};
  brmc_top #(.RESET_CYCLES(RST_CYC), .DEBOUNCE_CYCLES(DB_CYC)) i_brmc_top (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .reset_button_n_in(btn_n[0]),
    .boot_button_n_in(btn_n[1]), .nmi_button_n_in(btn_n[2]), .host_cts_n_in(btn_n[3]),
    .user_program_enable_option_in(upe), .target_reset_n_out(rst_n), .target_nmi_n_out(nmi_n),
    .mode_pin_out(md_out), .mode_pin_oe_out(md_oe), .flash_write_protect_out(wp),
    .host_rts_out(rts), .boot_led_out(led));
  brmc_target_model i_brmc_target_model (
    .clk_sys_in(clk_sys_in), .target_reset_n_in(rst_n), .target_nmi_n_in(nmi_n),
    .mode_pin_in(md_bus), .latched_mode_out(latched), .nmi_count_out(nmi_cnt), .nmi_width_out(nmi_w));
  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic press(input int b, input int hold);
    @(negedge clk_sys_in);
    btn_n[b] = 1'b0;
    repeat (hold) @(negedge clk_sys_in);
    btn_n[b] = 1'b1;
  endtask
  // cycles until the target leaves reset, bounded
  task automatic wait_run(output int n);
    n = 0;
    while (rst_n !== 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (3) @(negedge clk_sys_in);
    reset_in = 1'b0;
    chk("status in power-up reset", 11'h000, st);
    wait_run(t);
    chk("power-up reset long enough", 1, t >= RST_CYC);
    chk("status user run", 11'h400, st);
    chk("mode latched from jumpers", JUMPER_MODE, latched);
    $display("test power_up done");
    upe = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    chk("write protect off", 0, wp);
    upe = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk("write protect on", 1, wp);
    press(2, 30);
    repeat (20) @(negedge clk_sys_in);
    chk("nmi count long hold", 1, nmi_cnt);
    chk("nmi width", BRMC_NMI_PULSE_CYCLES, nmi_w);
    press(2, DB_CYC + 2);
    repeat (20) @(negedge clk_sys_in);
    chk("nmi count short hold", 2, nmi_cnt);
    $display("test nmi done");
    press(1, 12);
    chk("status boot reset", 11'h3f0, st);
    wait_run(t);
    chk("boot reset long enough", 1, t >= RST_CYC);
    chk("status boot run", 11'h7f0, st);
    chk("boot mode latched", BRMC_BOOT_MODE, latched);
    press(2, 12);
    repeat (20) @(negedge clk_sys_in);
    chk("nmi refused in boot mode", 2, nmi_cnt);
    $display("test boot_entry done");
    press(3, 12);
    chk("status after cts press", 11'h000, st);
    repeat (30) @(negedge clk_sys_in);
    press(1, 12);
    chk("boot press in reset ignored", 11'h000, st);
    wait_run(t);
    chk("timer restarted by boot press", 1, t >= RST_CYC);
    chk("status user run again", 11'h400, st);
    chk("user mode latched", JUMPER_MODE, latched);
    $display("test boot_exit done");
    press(0, 100);
    chk("reset held with button", 11'h000, st);
    wait_run(t);
    chk("reset extended after release", 1, t >= RST_CYC);
    chk("status after reset button", 11'h400, st);
    $display("test reset_button done");
    stop_test();
  end
endmodule
